//--- logic/sgc_pkg.sv
// package: offsets, field positions, reset values and timing counts for the global control bits
package sgc_pkg;
  // register indices (byte registers on the plain port)
  localparam logic [7:0] CTRL_ZERO_ADDR = 8'h02;
  localparam logic [7:0] CTRL_ONE_ADDR = 8'h03;
  // control zero fields
  localparam int PHY_MII_EN_BIT = 3;
  localparam int BUF_SHARE_BIT = 2;
  localparam int CONF_DROP_BIT = 1;
  localparam int LINK_AGE_BIT = 0;
  // control one fields
  localparam int PASS_ALL_BIT = 7;
  localparam int TX_FC_DIS_BIT = 5;
  localparam int RX_FC_DIS_BIT = 4;
  localparam int LEN_CHECK_BIT = 3;
  localparam int AGING_EN_BIT = 2;
  // reset values of non-strapped bits
  localparam logic BUF_SHARE_RST = 1'b1;
  localparam logic CONF_DROP_RST = 1'b0;
  localparam logic LINK_AGE_RST = 1'b0;
  localparam logic PASS_ALL_RST = 1'b0;
  localparam logic LEN_CHECK_RST = 1'b0;
  // frame constants
  localparam logic [15:0] PAUSE_TYPE = 16'h8808;
  localparam logic [47:0] PAUSE_DA = 48'h0180_C200_0001;
  localparam logic [15:0] MAX_LEN_FIELD = 16'h05DC;
  // buffer pool
  localparam logic [9:0] POOL_BUFFERS = 10'h0280;
  localparam logic [9:0] PORT_QUOTA = 10'h0080; // one fifth of the pool
  localparam int NUM_PORTS = 5;
  // timing
  localparam int CLK_MHZ = 250;
  localparam int FAST_AGE_US = 800;
  localparam int FAST_AGE_CYC = FAST_AGE_US * CLK_MHZ - 2; // pass runs one more, stays under
  localparam int NORMAL_AGE_S = 300;
  localparam int AGE_TOL_S = 75;
  localparam int AGE_TABLE_DEPTH = 1024;
endpackage

//--- logic/sgc_port_gate.sv
// one port's buffer quota and flow-control resolution
`timescale 1ns/1ps
module sgc_port_gate (
  input wire logic clk,
  input wire logic rst,
  input wire logic buf_share,
  input wire logic tx_fc_dis,
  input wire logic rx_fc_dis,
  input wire logic an_pause,
  input wire logic buf_take,
  input wire logic buf_free,
  output logic buf_ok,
  output logic tx_fc,
  output logic rx_fc
);
  logic [9:0] used; // buffers held by this port

  // count buffers; nothing in the top guards the pool itself
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      used <= 10'h0000;
    else if (buf_take && !buf_free)
      used <= used + 10'h0001;
    else if (buf_free && !buf_take && used != 10'h0000)
      used <= used - 10'h0001;
  end

  // quota applies only when sharing is off
  always_comb
  begin
    buf_ok = buf_share || (used < sgc_pkg::PORT_QUOTA);
  end

  // pause follows negotiation unless disabled by software or by the pause strap
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_fc <= 1'b0;
      rx_fc <= 1'b0;
    end
    else
    begin
      tx_fc <= an_pause && !tx_fc_dis;
      rx_fc <= an_pause && !rx_fc_dis;
    end
  end

  a_quota_cap: assert property (@(posedge clk) disable iff (rst)
    !buf_share && used >= sgc_pkg::PORT_QUOTA |-> !buf_ok)
    else $error("quota not enforced");
endmodule

//--- logic/sgc_global_ctrl.sv
// top: global control bits of the switch and the logic they steer
// Overview of operation
// - bit set drives PHY MII, clear tri-states
// - sharing on lets ports use whole pool
// - sharing off caps port at one fifth
// - conformance mode drops pause type or DA
// - otherwise drop only real flow-control frames
// - link loss with bit set starts fast aging
// - after fast aging return to normal period
// - unplugged port ages out all addresses
// - pass-all forwards errored frames too, resets zero
// - transmit pause follows negotiation unless disabled
// - receive pause follows negotiation unless disabled
// - one strap loads both pause bits
// - strap low enables pause, high disables
// - length check drops mismatched frames with length field below 05DC
// - aging runs only while enable bit set
// - aging enable default comes from strap
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module sgc_global_ctrl #(
  parameter int FAST_AGE_CYCLES = sgc_pkg::FAST_AGE_CYC,
  parameter int NORMAL_AGE_CYCLES = 1000000
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic PHY_PORT_ENABLE_STRAP_PIN,
  input wire logic FLOW_CTRL_STRAP_PIN,
  input wire logic AGING_STRAP_PIN,
  input wire logic [4:0] LINK_UP,
  input wire logic [4:0] AN_PAUSE,
  input wire logic [4:0] BUF_TAKE,
  input wire logic [4:0] BUF_FREE,
  output logic [4:0] BUF_OK,
  output logic [4:0] TX_FC,
  output logic [4:0] RX_FC,
  output logic PHY_MII_OE_N,
  input wire logic FRAME_VALID,
  input wire logic [47:0] FRAME_DA,
  input wire logic [15:0] FRAME_TYPE_LEN,
  input wire logic [15:0] FRAME_PAYLOAD_LEN,
  input wire logic FRAME_ERROR,
  input wire logic FRAME_IS_PAUSE,
  output logic FRAME_DROP,
  output logic AGE_TICK,
  output logic AGE_FLUSH,
  output logic FAST_AGING
);
  ////////////////////////////////////////////////////////////////////////////
  // control registers
  logic phy_mii_en; // interface drive enable
  logic buf_share; // shared pool
  logic conf_drop; // conformance drop mode
  logic link_age; // fast age on link loss
  logic pass_all; // debug forwarding
  logic tx_fc_dis; // transmit pause off
  logic rx_fc_dis; // receive pause off
  logic len_check; // length field check
  logic aging_en; // aging on
  logic strap_load; // one cycle after reset release
  logic [7:0] ctrl_zero; // read view
  logic [7:0] ctrl_one; // read view

  // straps are caught by the clock after release, never inside the reset term
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      strap_load <= 1'b1;
    else
      strap_load <= 1'b0;
  end

  // control zero bits
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      phy_mii_en <= 1'b1;
      buf_share <= sgc_pkg::BUF_SHARE_RST;
      conf_drop <= sgc_pkg::CONF_DROP_RST;
      link_age <= sgc_pkg::LINK_AGE_RST;
    end
    else if (strap_load)
      phy_mii_en <= PHY_PORT_ENABLE_STRAP_PIN;
    else if (WR && ADDR == sgc_pkg::CTRL_ZERO_ADDR)
    begin
      phy_mii_en <= WDATA[sgc_pkg::PHY_MII_EN_BIT];
      buf_share <= WDATA[sgc_pkg::BUF_SHARE_BIT];
      conf_drop <= WDATA[sgc_pkg::CONF_DROP_BIT];
      link_age <= WDATA[sgc_pkg::LINK_AGE_BIT];
    end
  end

  // control one bits; a write in the strap cycle loses, which cannot happen legally
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      pass_all <= sgc_pkg::PASS_ALL_RST;
      tx_fc_dis <= 1'b1; // pause held off until the strap lands, no glitch
      rx_fc_dis <= 1'b1; // same for receive
      len_check <= sgc_pkg::LEN_CHECK_RST;
      aging_en <= 1'b1;
    end
    else if (strap_load)
    begin
      tx_fc_dis <= FLOW_CTRL_STRAP_PIN;
      rx_fc_dis <= FLOW_CTRL_STRAP_PIN;
      aging_en <= AGING_STRAP_PIN;
    end
    else if (WR && ADDR == sgc_pkg::CTRL_ONE_ADDR)
    begin
      pass_all <= WDATA[sgc_pkg::PASS_ALL_BIT];
      tx_fc_dis <= WDATA[sgc_pkg::TX_FC_DIS_BIT];
      rx_fc_dis <= WDATA[sgc_pkg::RX_FC_DIS_BIT];
      len_check <= WDATA[sgc_pkg::LEN_CHECK_BIT];
      aging_en <= WDATA[sgc_pkg::AGING_EN_BIT];
    end
  end

  // read views; unused bits of these registers read zero here
  always_comb
  begin
    ctrl_zero = 8'h00;
    ctrl_zero[sgc_pkg::PHY_MII_EN_BIT] = phy_mii_en;
    ctrl_zero[sgc_pkg::BUF_SHARE_BIT] = buf_share;
    ctrl_zero[sgc_pkg::CONF_DROP_BIT] = conf_drop;
    ctrl_zero[sgc_pkg::LINK_AGE_BIT] = link_age;
    ctrl_one = 8'h00;
    ctrl_one[sgc_pkg::PASS_ALL_BIT] = pass_all;
    ctrl_one[sgc_pkg::TX_FC_DIS_BIT] = tx_fc_dis;
    ctrl_one[sgc_pkg::RX_FC_DIS_BIT] = rx_fc_dis;
    ctrl_one[sgc_pkg::LEN_CHECK_BIT] = len_check;
    ctrl_one[sgc_pkg::AGING_EN_BIT] = aging_en;
  end

  // read data stand one cycle after the strobe and only then
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      RDATA <= 8'h00;
    else if (RD && ADDR == sgc_pkg::CTRL_ZERO_ADDR)
      RDATA <= ctrl_zero;
    else if (RD && ADDR == sgc_pkg::CTRL_ONE_ADDR)
      RDATA <= ctrl_one;
    else
      RDATA <= 8'h00; // unmapped or idle
  end

  ////////////////////////////////////////////////////////////////////////////
  // phy-mode interface drive

  // output enable is active low: low while driving
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      PHY_MII_OE_N <= 1'b1;
    else
      PHY_MII_OE_N <= !phy_mii_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-port buffer quota and pause resolution
  logic [4:0] buf_ok_c; // combinational grant per port
  logic [4:0] tx_fc_c; // resolved pause
  logic [4:0] rx_fc_c;

  for (genvar p = 0; p < sgc_pkg::NUM_PORTS; p++)
  begin : g_port
    sgc_port_gate u_gate (
      .clk(CLK),
      .rst(RST),
      .buf_share(buf_share),
      .tx_fc_dis(tx_fc_dis),
      .rx_fc_dis(rx_fc_dis),
      .an_pause(AN_PAUSE[p]),
      .buf_take(BUF_TAKE[p]),
      .buf_free(BUF_FREE[p]),
      .buf_ok(buf_ok_c[p]),
      .tx_fc(tx_fc_c[p]),
      .rx_fc(rx_fc_c[p])
    );
  end

  // register the grants so every output leaves a flip-flop
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      BUF_OK <= 5'h00;
      TX_FC <= 5'h00;
      RX_FC <= 5'h00;
    end
    else
    begin
      BUF_OK <= buf_ok_c;
      TX_FC <= tx_fc_c;
      RX_FC <= rx_fc_c;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame filter
  logic conf_hit; // pause type or reserved group address
  logic len_bad; // length field mismatch
  logic next_drop;

  // drop decision for one frame, presented for one cycle
  always_comb
  begin
    conf_hit = FRAME_TYPE_LEN == sgc_pkg::PAUSE_TYPE || FRAME_DA == sgc_pkg::PAUSE_DA;
    len_bad = len_check && FRAME_TYPE_LEN < sgc_pkg::MAX_LEN_FIELD
      && FRAME_TYPE_LEN != FRAME_PAYLOAD_LEN;
    next_drop = 1'b0;
    if (FRAME_VALID)
    begin
      if (conf_drop ? conf_hit : FRAME_IS_PAUSE)
        next_drop = 1'b1;
      else if (pass_all)
        next_drop = 1'b0;
      else if (FRAME_ERROR || len_bad)
        next_drop = 1'b1;
    end
  end

  // one-cycle drop pulse after the frame strobe
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      FRAME_DROP <= 1'b0;
    else
      FRAME_DROP <= next_drop;
  end

  ////////////////////////////////////////////////////////////////////////////
  // aging timer
  logic [4:0] link_q; // link state last cycle
  logic link_lost; // any port went down
  logic [31:0] age_cnt; // cycles since the last tick
  logic [31:0] age_limit;

  // remember link state for the fall detector
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      link_q <= 5'h00;
    else
      link_q <= LINK_UP;
  end

  always_comb
  begin
    link_lost = |(link_q & ~LINK_UP);
    age_limit = FAST_AGING ? 32'(FAST_AGE_CYCLES) : 32'(NORMAL_AGE_CYCLES);
  end

  // unplug flushes the table; fast aging starts only when the bit is set
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      AGE_FLUSH <= 1'b0;
    else
      AGE_FLUSH <= link_lost;
  end

  // fast cycle ends after one pass, then normal period resumes
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      FAST_AGING <= 1'b0;
    else if (link_lost && link_age && aging_en)
      FAST_AGING <= 1'b1;
    else if (FAST_AGING && age_cnt >= age_limit)
      FAST_AGING <= 1'b0;
  end

  // tick counter frozen while aging is disabled
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      age_cnt <= 32'h0000_0000;
      AGE_TICK <= 1'b0;
    end
    else if (!aging_en)
    begin
      AGE_TICK <= 1'b0;
    end
    else if (link_lost && link_age)
    begin
      age_cnt <= 32'h0000_0000;
      AGE_TICK <= 1'b0;
    end
    else if (age_cnt >= age_limit)
    begin
      age_cnt <= 32'h0000_0000;
      AGE_TICK <= 1'b1;
    end
    else
    begin
      age_cnt <= age_cnt + 32'h0000_0001;
      AGE_TICK <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_mii_drive: assert property (@(posedge CLK) disable iff (RST)
    !strap_load |=> PHY_MII_OE_N == !$past(phy_mii_en))
    else $error("mii enable not followed");
  a_conf_drop: assert property (@(posedge CLK) disable iff (RST)
    FRAME_VALID && conf_drop && FRAME_TYPE_LEN == sgc_pkg::PAUSE_TYPE |=> FRAME_DROP)
    else $error("conformance frame kept");
  a_pause_drop: assert property (@(posedge CLK) disable iff (RST)
    FRAME_VALID && !conf_drop && FRAME_IS_PAUSE |=> FRAME_DROP)
    else $error("pause frame kept");
  a_pass_errors: assert property (@(posedge CLK) disable iff (RST)
    FRAME_VALID && pass_all && !FRAME_IS_PAUSE && !conf_drop |=> !FRAME_DROP)
    else $error("pass-all dropped a frame");
  a_len_drop: assert property (@(posedge CLK) disable iff (RST)
    FRAME_VALID && !pass_all && len_bad |=> FRAME_DROP)
    else $error("length mismatch kept");
  a_tx_pause_off: assert property (@(posedge CLK) disable iff (RST)
    tx_fc_dis && $past(tx_fc_dis) |=> TX_FC == 5'h00)
    else $error("tx pause while disabled");
  a_rx_pause_off: assert property (@(posedge CLK) disable iff (RST)
    rx_fc_dis && $past(rx_fc_dis) |=> RX_FC == 5'h00)
    else $error("rx pause while disabled");
  a_strap_load: assert property (@(posedge CLK) disable iff (RST)
    strap_load |=> tx_fc_dis == $past(FLOW_CTRL_STRAP_PIN)
      && rx_fc_dis == $past(FLOW_CTRL_STRAP_PIN))
    else $error("pause strap not loaded");
  a_aging_hold: assert property (@(posedge CLK) disable iff (RST)
    !aging_en |=> !AGE_TICK && $stable(age_cnt))
    else $error("aging ran while disabled");
  a_fast_start: assert property (@(posedge CLK) disable iff (RST)
    link_lost && link_age && aging_en |=> FAST_AGING && AGE_FLUSH)
    else $error("fast aging not started");
  c_fast_age: cover property (@(posedge CLK) disable iff (RST) $fell(FAST_AGING));
  c_drop: cover property (@(posedge CLK) disable iff (RST) FRAME_DROP);
  c_write_one: cover property (@(posedge CLK) disable iff (RST)
    WR && ADDR == sgc_pkg::CTRL_ONE_ADDR);
endmodule

//--- test/sgc_testbench.sv
// testbench for the global control bits: registers, straps, frame filter, quotas, aging
`timescale 1ns/1ps
module testbench;
  localparam int FAST_CYC = 20; // shortened fast aging pass
  localparam int NORM_CYC = 50; // shortened normal aging period
  localparam logic [7:0] A0 = sgc_pkg::CTRL_ZERO_ADDR; // control zero index
  localparam logic [7:0] A1 = sgc_pkg::CTRL_ONE_ADDR; // control one index
  localparam logic [47:0] DA_N = 48'h0011_2233_4455; // ordinary unicast address
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [7:0] RDATA;
  logic PHY_PORT_ENABLE_STRAP_PIN = 1'b1; // straps start at their pulled levels
  logic FLOW_CTRL_STRAP_PIN = 1'b0;
  logic AGING_STRAP_PIN = 1'b1;
  logic [4:0] LINK_UP = 5'h1F;
  logic [4:0] AN_PAUSE = 5'h1F;
  logic [4:0] BUF_TAKE = 5'h00;
  logic [4:0] BUF_FREE = 5'h00;
  logic [4:0] BUF_OK, TX_FC, RX_FC;
  logic PHY_MII_OE_N, FRAME_DROP, AGE_TICK, AGE_FLUSH, FAST_AGING;
  logic FRAME_VALID = 1'b0;
  logic [47:0] FRAME_DA = 48'h0000_0000_0000;
  logic [15:0] FRAME_TYPE_LEN = 16'h0000;
  logic [15:0] FRAME_PAYLOAD_LEN = 16'h0000;
  logic FRAME_ERROR = 1'b0;
  logic FRAME_IS_PAUSE = 1'b0;
  int err_count = 0;
  int total_checks = 0;
  int n;

  ////////////////////////////////////////////////////////////////////////////////
  // short aging counts keep the run small; expectations derive from them
  sgc_global_ctrl #(.FAST_AGE_CYCLES(FAST_CYC), .NORMAL_AGE_CYCLES(NORM_CYC)) u_sgc_global_ctrl (
    .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .PHY_PORT_ENABLE_STRAP_PIN(PHY_PORT_ENABLE_STRAP_PIN),
    .FLOW_CTRL_STRAP_PIN(FLOW_CTRL_STRAP_PIN), .AGING_STRAP_PIN(AGING_STRAP_PIN),
    .LINK_UP(LINK_UP), .AN_PAUSE(AN_PAUSE), .BUF_TAKE(BUF_TAKE), .BUF_FREE(BUF_FREE),
    .BUF_OK(BUF_OK), .TX_FC(TX_FC), .RX_FC(RX_FC), .PHY_MII_OE_N(PHY_MII_OE_N),
    .FRAME_VALID(FRAME_VALID), .FRAME_DA(FRAME_DA), .FRAME_TYPE_LEN(FRAME_TYPE_LEN),
    .FRAME_PAYLOAD_LEN(FRAME_PAYLOAD_LEN), .FRAME_ERROR(FRAME_ERROR),
    .FRAME_IS_PAUSE(FRAME_IS_PAUSE), .FRAME_DROP(FRAME_DROP), .AGE_TICK(AGE_TICK),
    .AGE_FLUSH(AGE_FLUSH), .FAST_AGING(FAST_AGING));

  // 4 ns period
  always #2 CLK = ~CLK;

  ////////////////////////////////////////////////////////////////////////////////
  // compare, counted; four-state so an unknown never matches
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // let k edges pass, then sample settled outputs
  task automatic cyc(input int k);
    repeat (k) @(posedge CLK);
    #1;
  endtask

  // one-cycle write; the return edge leaves a gap so WR is never set twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  // one-cycle read; data stands only in the following cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    chk("rdata", {8'h00, exp}, {8'h00, RDATA});
  endtask

  // one frame; the drop verdict stands one cycle after it is taken
  task automatic frm(input logic [47:0] da, input logic [15:0] tl, pl, input logic e, p, x);
    @(posedge CLK);
    FRAME_VALID <= 1'b1;
    FRAME_DA <= da;
    FRAME_TYPE_LEN <= tl;
    FRAME_PAYLOAD_LEN <= pl;
    FRAME_ERROR <= e;
    FRAME_IS_PAUSE <= p;
    @(posedge CLK);
    FRAME_VALID <= 1'b0;
    #1;
    chk("drop", {15'h0000, x}, {15'h0000, FRAME_DROP});
  endtask

  // k separate take (or free) pulses on port 0
  task automatic bufp(input logic take, input int k);
    repeat (k)
    begin
      @(posedge CLK);
      BUF_TAKE <= {4'h0, take};
      BUF_FREE <= {4'h0, ~take};
      @(posedge CLK);
      BUF_TAKE <= 5'h00;
      BUF_FREE <= 5'h00;
    end
  endtask

  // cycles until the next aging tick, capped at 200
  task automatic gap(output int k);
    k = 0;
    do
    begin
      cyc(1);
      k++;
    end
    while (AGE_TICK !== 1'b1 && k < 200);
  endtask

  // drop the link on the port given by mask, wait up to 6 cycles for the flush
  task automatic drop_link(input logic [4:0] up);
    @(posedge CLK);
    LINK_UP <= up;
    n = 0;
    while (AGE_FLUSH !== 1'b1 && n < 6)
    begin
      cyc(1);
      n++;
    end
  endtask

  // reset for 6 cycles with the given strap levels, launched on a rising edge
  task automatic do_reset(input logic phy, fc, ag);
    @(posedge CLK);
    PHY_PORT_ENABLE_STRAP_PIN <= phy;
    FLOW_CTRL_STRAP_PIN <= fc;
    AGING_STRAP_PIN <= ag;
    RST <= 1'b1;
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
  endtask

  // verdict and end of run, shared by the sequence and the watchdog
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the sequence needs under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge CLK);
    err_count++;
    results();
  end

  // main sequence
  initial
  begin
    do_reset(1'b1, 1'b1, 1'b1);
    rd(A0, 8'h0C);
    rd(A1, 8'h34);
    chk("oe_n", 16'h0000, {15'h0000, PHY_MII_OE_N});
    chk("tx_fc", 16'h0000, {11'h000, TX_FC});
    $display("test strap_high done");
    wr(A1, 8'h24);
    rd(A1, 8'h24);
    cyc(3);
    chk("tx_fc", 16'h0000, {11'h000, TX_FC});
    chk("rx_fc", 16'h001F, {11'h000, RX_FC});
    wr(A1, 8'h14);
    cyc(3);
    chk("tx_fc", 16'h001F, {11'h000, TX_FC});
    chk("rx_fc", 16'h0000, {11'h000, RX_FC});
    wr(8'h05, 8'hFF);
    rd(8'h05, 8'h00);
    wr(A0, 8'hFF);
    rd(A0, 8'h0F);
    wr(A0, 8'h04);
    cyc(3);
    chk("oe_n", 16'h0001, {15'h0000, PHY_MII_OE_N});
    $display("test registers done");
    // filter: plain mode drops only flagged flow-control frames
    frm(DA_N, 16'h0800, 16'h0040, 1'b0, 1'b1, 1'b1);
    frm(DA_N, 16'h8808, 16'h0040, 1'b0, 1'b0, 1'b0);
    frm(sgc_pkg::PAUSE_DA, 16'h0800, 16'h0040, 1'b0, 1'b0, 1'b0);
    wr(A0, 8'h0E);
    frm(DA_N, 16'h8808, 16'h0040, 1'b0, 1'b0, 1'b1);
    frm(sgc_pkg::PAUSE_DA, 16'h0800, 16'h0040, 1'b0, 1'b0, 1'b1);
    frm(DA_N, 16'h0800, 16'h0040, 1'b0, 1'b0, 1'b0);
    wr(A0, 8'h0C);
    wr(A1, 8'h1C);
    frm(DA_N, 16'h0040, 16'h0041, 1'b0, 1'b0, 1'b1);
    frm(DA_N, 16'h0040, 16'h0040, 1'b0, 1'b0, 1'b0);
    frm(DA_N, 16'h05DB, 16'h0000, 1'b0, 1'b0, 1'b1);
    frm(DA_N, 16'h05DC, 16'h0000, 1'b0, 1'b0, 1'b0);
    frm(DA_N, 16'h0800, 16'h0040, 1'b1, 1'b0, 1'b1);
    wr(A1, 8'h9C);
    frm(DA_N, 16'h0800, 16'h0040, 1'b1, 1'b0, 1'b0);
    frm(DA_N, 16'h0040, 16'h0041, 1'b0, 1'b0, 1'b0);
    frm(DA_N, 16'h0800, 16'h0040, 1'b0, 1'b1, 1'b1);
    wr(A1, 8'h14);
    $display("test filter done");
    // quota: one fifth of the pool per port while sharing is off
    wr(A0, 8'h08);
    bufp(1'b1, 127);
    cyc(3);
    chk("buf_ok", 16'h001F, {11'h000, BUF_OK});
    bufp(1'b1, 1);
    cyc(3);
    chk("buf_ok", 16'h001E, {11'h000, BUF_OK});
    wr(A0, 8'h0C);
    cyc(3);
    chk("buf_ok", 16'h001F, {11'h000, BUF_OK});
    wr(A0, 8'h08);
    cyc(3);
    chk("buf_ok", 16'h001E, {11'h000, BUF_OK});
    bufp(1'b0, 1);
    cyc(3);
    chk("buf_ok", 16'h001F, {11'h000, BUF_OK});
    $display("test buffers done");
    // aging: fast pass on link loss, then the normal period
    wr(A0, 8'h0D);
    drop_link(5'h1B);
    chk("flush", 16'h0001, {15'h0000, AGE_FLUSH});
    chk("fast", 16'h0001, {15'h0000, FAST_AGING});
    n = 0;
    while (FAST_AGING === 1'b1 && n < 1000)
    begin
      cyc(1);
      n++;
    end
    chk("fast_len", 16'(FAST_CYC + 1), n[15:0]);
    gap(n);
    gap(n);
    chk("period", 16'h0001, {15'h0000, n >= NORM_CYC * 3 / 4 && n <= NORM_CYC * 5 / 4});
    wr(A0, 8'h0C);
    @(posedge CLK);
    LINK_UP <= 5'h1F;
    cyc(3);
    drop_link(5'h1E);
    chk("flush", 16'h0001, {15'h0000, AGE_FLUSH});
    chk("fast", 16'h0000, {15'h0000, FAST_AGING});
    wr(A1, 8'h10);
    gap(n);
    chk("no_tick", 16'h00C8, n[15:0]);
    $display("test aging done");
    // second reset with straps low
    do_reset(1'b0, 1'b0, 1'b0);
    rd(A0, 8'h04);
    rd(A1, 8'h00);
    chk("oe_n", 16'h0001, {15'h0000, PHY_MII_OE_N});
    chk("rx_fc", 16'h001F, {11'h000, RX_FC});
    gap(n);
    chk("no_tick", 16'h00C8, n[15:0]);
    $display("test strap_low done");
    results();
  end
endmodule
